// file: eio_point_access.v
// Summary of operation
// - A point is named by board digit 1 to 4 and point number 00 to 47, for inputs and outputs.
// - A multi-point access covers 1 to 24 consecutive points from the addressed first point.
// - A single input read returns one bit, 1 for on and 0 for off.
// - A multi input read returns an unsigned word with the first point in bit 0.
// - A single output write turns the point on for any non-zero value and off for zero.
// - A single output read returns the stored last command, not the pin level.
// - A multi output write drives the low count bits of the integer value, bit 0 first.
// - A multi output read returns the stored commands of the run, first point in bit 0.
`include "eio_consts.vh"

module eio_point_access (
	input  wire         mclk_i,
	input  wire         resetn_i,
	input  wire         req_i,
	input  wire         req_write_i,
	input  wire         req_output_i,
	input  wire         req_multi_i,
	input  wire [3:0]   req_board_i,
	input  wire [6:0]   req_point_i,
	input  wire [4:0]   req_len_i,
	input  wire [31:0]  req_wdata_i,
	input  wire [191:0] exp_in_i,
	output wire [191:0] exp_out_o,
	output reg  [23:0]  rdata_o,
	output reg          rvalid_o
);

	// ----------------------------------------
	// Point decode functions
	// ----------------------------------------
	// Board digit and point number both in range
	function pt_valid;
		input [3:0] board;
		input [7:0] point;
		begin
			pt_valid = (board >= `EIO_BOARD_MIN) &&
			           (board <= `EIO_BOARD_MAX) &&
			           (point <= {1'b0, `EIO_POINT_MAX});
		end
	endfunction

	// Base of a board in the flat point vector
	function [7:0] board_base;
		input [3:0] board;
		begin
			case (board)
				4'h1:    board_base = `EIO_BASE_B1;
				4'h2:    board_base = `EIO_BASE_B2;
				4'h3:    board_base = `EIO_BASE_B3;
				4'h4:    board_base = `EIO_BASE_B4;
				default: board_base = `EIO_BASE_B1;
			endcase
		end
	endfunction

	// Flat index; the marker value lies past every real point
	function [7:0] pt_index;
		input [3:0] board;
		input [7:0] point;
		begin
			if (pt_valid(board, point))
				pt_index = board_base(board) + point;
			else
				pt_index = `EIO_BAD_IDX;
		end
	endfunction

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	reg  [191:0] in_meta_reg;
	reg  [191:0] in_sync_reg;
	reg  [191:0] out_reg;
	reg  [191:0] out_next;
	reg  [23:0]  rdata_next;
	reg          rvalid_next;
	wire         rd_req;
	wire         wr_req;
	wire         len_ok;
	wire [4:0]   eff_len;
	wire [7:0]   first_pt;
	wire [23:0]  lane_ok;
	wire [23:0]  lane_val;
	wire [23:0]  lane_in;
	wire [23:0]  lane_out;
	wire [7:0]   lane_idx [0:23];
	wire [191:0] pt_hit;
	wire [191:0] pt_wbit;
	genvar       g;
	genvar       p;
	genvar       q;

	// ----------------------------------------
	// Request decode
	// ----------------------------------------
	// Zero or over-long counts are refused; single access always one point
	assign len_ok = !req_multi_i ||
	                (req_len_i >= `EIO_LEN_MIN && req_len_i <= `EIO_LEN_MAX);
	assign eff_len = req_multi_i ? req_len_i : `EIO_LEN_MIN;
	// Writes aimed at input points are dropped here
	assign wr_req = req_i && req_write_i && req_output_i && len_ok;
	assign rd_req = req_i && !req_write_i;
	// Spare top bit, so a run from a bad point cannot wrap onto point 0
	assign first_pt = {1'b0, req_point_i};

	// ----------------------------------------
	// Pin outputs
	// ----------------------------------------
	// Stored command straight to the pins, no extra stage
	assign exp_out_o = out_reg;

	// ----------------------------------------
	// Run lanes, one per position in the run
	// ----------------------------------------
	// Runs never wrap onto the next board: a point past 47 is out of range
	generate
		for (g = 0; g < `EIO_MAX_LEN; g = g + 1) begin : g_lane
			localparam integer LANE = g;
			assign lane_idx[g] = pt_index(req_board_i, first_pt + LANE[7:0]);
			assign lane_ok[g]  = (LANE[4:0] < eff_len) &&
			                     pt_valid(req_board_i, first_pt + LANE[7:0]);
			assign lane_val[g] = req_multi_i ? req_wdata_i[g] : |req_wdata_i;
			assign lane_in[g]  = lane_ok[g] ? in_sync_reg[lane_idx[g]] : 1'b0;
			assign lane_out[g] = lane_ok[g] ? out_reg[lane_idx[g]] : 1'b0;
		end
	endgenerate

	// ----------------------------------------
	// Point write decode
	// ----------------------------------------
	// Each point looks for the lane, if any, that addresses it
	generate
		for (p = 0; p < `EIO_NPTS; p = p + 1) begin : g_point
			localparam integer PT = p;
			wire [23:0] lane_hit;
			for (q = 0; q < `EIO_MAX_LEN; q = q + 1) begin : g_match
				assign lane_hit[q] = lane_ok[q] && (lane_idx[q] == PT[7:0]);
			end
			assign pt_hit[p]  = |lane_hit;
			assign pt_wbit[p] = |(lane_hit & lane_val);
		end
	endgenerate

	// ----------------------------------------
	// Output store next state
	// ----------------------------------------
	// Points outside the run, or out of range, keep their command
	always @* begin
		out_next = out_reg;
		if (wr_req) begin
			out_next = (out_reg & ~pt_hit) | pt_wbit;
		end
	end

	// ----------------------------------------
	// Read path next state
	// ----------------------------------------
	// Refused count still answers, data left as it was
	always @* begin
		rdata_next  = rdata_o;
		rvalid_next = 1'b0;
		if (rd_req) begin
			rvalid_next = 1'b1;
			if (len_ok) begin
				if (req_output_i) begin
					rdata_next = lane_out;
				end else begin
					rdata_next = lane_in;
				end
			end
		end
	end

	// ----------------------------------------
	// Input synchroniser
	// ----------------------------------------
	// Pins are asynchronous; only the second stage feeds reads
	always @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			in_meta_reg <= `EIO_IN_RESET;
			in_sync_reg <= `EIO_IN_RESET;
		end else begin
			in_meta_reg <= exp_in_i;
			in_sync_reg <= in_meta_reg;
		end
	end

	// ----------------------------------------
	// Output command store
	// ----------------------------------------
	// Output reads use this store, never the pins
	always @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			out_reg <= `EIO_OUT_RESET;
		end else begin
			out_reg <= out_next;
		end
	end

	// ----------------------------------------
	// Read result registers
	// ----------------------------------------
	// Data holds until the next accepted read
	always @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_o <= `EIO_RDATA_RESET;
		end else begin
			rdata_o <= rdata_next;
		end
	end

	// One-cycle answer strobe
	always @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rvalid_o <= 1'b0;
		end else begin
			rvalid_o <= rvalid_next;
		end
	end

endmodule // eio_point_access

// file: eio_consts.vh
`ifndef EIO_CONSTS_VH
`define EIO_CONSTS_VH
// ----------------------------------------
// Point addressing
// ----------------------------------------
`define EIO_BOARDS       3'h4
`define EIO_PTS_PER_BRD  6'h30
`define EIO_NPTS         8'hC0
`define EIO_MAX_LEN      5'h18
`define EIO_BOARD_MIN    4'h1
`define EIO_BOARD_MAX    4'h4
`define EIO_POINT_MAX    7'h2F
`define EIO_LEN_MIN      5'h01
`define EIO_LEN_MAX      5'h18
// ----------------------------------------
// Flat point vector layout
// ----------------------------------------
`define EIO_BASE_B1      8'h00
`define EIO_BASE_B2      8'h30
`define EIO_BASE_B3      8'h60
`define EIO_BASE_B4      8'h90
`define EIO_BAD_IDX      8'hFF
// ----------------------------------------
// Reset values
// ----------------------------------------
`define EIO_IN_RESET     192'h0
`define EIO_OUT_RESET    192'h0
`define EIO_RDATA_RESET  24'h000000
`endif

// file: eio_boards.sv
module eio_boards(input logic [191:0] pat_i, output logic [191:0] exp_in_o);
	timeunit 1ns; timeprecision 1ns;
	// Pins change off the clock, so the sync stages matter
	assign #7 exp_in_o = pat_i;
endmodule // eio_boards

// file: eio_props.sv
module eio_props(input logic mclk_i, resetn_i, req_i, req_write_i, req_output_i, req_multi_i,
	input logic [3:0] req_board_i, input logic [6:0] req_point_i, input logic [4:0] req_len_i,
	input logic [31:0] req_wdata_i, input logic [191:0] exp_in_i, exp_out_o,
	input logic [23:0] rdata_o, input logic rvalid_o);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);
	wire rd = req_i && !req_write_i;
	wire at = !req_multi_i && req_board_i == 4'h2 && req_point_i == 7'h07;
	wire sw = req_i && req_write_i && req_output_i && at;
	AST_RV:
		assert property (rd |=> rvalid_o) else $error("read not answered");
	AST_NORV:
		assert property (!rd |=> !rvalid_o) else $error("stray read valid");
	AST_SON:
		assert property (sw && req_wdata_i != 0 |=> exp_out_o[55]) else $error("not on");
	AST_SOFF:
		assert property (sw && req_wdata_i == 0 |=> !exp_out_o[55]) else $error("not off");
	AST_HOLD:
		assert property (!(req_i && req_write_i && req_output_i) |=> $stable(exp_out_o))
			else $error("outputs moved");
	AST_BADLEN:
		assert property (rd && req_multi_i && (req_len_i == 5'h00 || req_len_i > 5'h18)
			|=> $stable(rdata_o)) else $error("bad count changed data");
	AST_SRD:
		assert property (rd && req_output_i && at |=> rdata_o == {23'h0, $past(exp_out_o[55])})
			else $error("output readback wrong");
	AST_RZ:
		assert property (rd && !req_multi_i && (req_board_i == 4'h0 || req_board_i > 4'h4)
			|=> rdata_o == 24'h0) else $error("bad board not zero");
	cover property (rd && req_multi_i);
	cover property (sw);
	cover property (rd && !req_output_i);
	cover property (rd && req_multi_i && req_len_i == 5'h00);
endmodule // eio_props
bind eio_point_access eio_props i_eio_props(.mclk_i(mclk_i), .resetn_i(resetn_i), .req_i(req_i),
	.req_write_i(req_write_i), .req_output_i(req_output_i), .req_multi_i(req_multi_i),
	.req_board_i(req_board_i), .req_point_i(req_point_i), .req_len_i(req_len_i),
	.req_wdata_i(req_wdata_i), .exp_in_i(exp_in_i), .exp_out_o(exp_out_o),
	.rdata_o(rdata_o), .rvalid_o(rvalid_o));

// file: eio_point_access_bench.sv
module eio_point_access_bench;
	timeunit 1ns; timeprecision 1ns;
	logic mclk_i = 0, resetn_i = 0, req_i = 0, req_write_i = 0, req_output_i = 0, req_multi_i = 0;
	logic [3:0] req_board_i = 0; logic [6:0] req_point_i = 0; logic [4:0] req_len_i = 0;
	logic [31:0] req_wdata_i = 0; logic [191:0] pat = 0, mo = 0, exp_in_i, exp_out_o;
	logic [23:0] rdata_o, lr = 0; logic rvalid_o; int n_fail = 0, n_tests = 0, seed = 27, i;
	logic [23:0] rq[$];
	eio_point_access i_eio_point_access(.mclk_i(mclk_i), .resetn_i(resetn_i), .req_i(req_i),
		.req_write_i(req_write_i), .req_output_i(req_output_i), .req_multi_i(req_multi_i),
		.req_board_i(req_board_i), .req_point_i(req_point_i), .req_len_i(req_len_i),
		.req_wdata_i(req_wdata_i), .exp_in_i(exp_in_i), .exp_out_o(exp_out_o),
		.rdata_o(rdata_o), .rvalid_o(rvalid_o));
	eio_boards i_eio_boards(.pat_i(pat), .exp_in_o(exp_in_i));
	task chk_v(input logic g, x);
		n_tests++;
		if (g !== x) begin n_fail++; $display("mismatch t=%0t got=%h exp=%h", $time, g, x); end
	endtask
	task chk_d(input logic [23:0] g, x);
		n_tests++;
		if (g !== x) begin n_fail++; $display("mismatch t=%0t got=%h exp=%h", $time, g, x); end
	endtask
	task chk_o(input logic [191:0] g, x);
		n_tests++;
		if (g !== x) begin n_fail++; $display("mismatch t=%0t got=%h exp=%h", $time, g, x); end
	endtask
	task conclude;
		$display("tests=%0d fails=%0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task acc(input logic w, o, m, input logic [3:0] b, input logic [6:0] p,
		input logic [4:0] l, input logic [31:0] d);
		int k, x; logic [23:0] e;
		e = 0;
		if (m && (l == 0 || l > 24)) e = lr;
		else for (k = 0; k < (m ? l : 1); k++) if (b > 0 && b < 5 && p + k < 48) begin
			x = (b - 1) * 48 + p + k;
			if (w && o) mo[x] = m ? d[k] : |d;
			e[k] = o ? mo[x] : pat[x];
		end
		if (!w) begin rq.push_back(e); lr = e; end
		{req_i, req_write_i, req_output_i, req_multi_i} = {1'b1, w, o, m};
		{req_board_i, req_point_i, req_len_i, req_wdata_i} = {b, p, l, d};
		@(posedge mclk_i); #2 req_i = 0;
		chk_v(rvalid_o, !w);
		if (!w) chk_d(rdata_o, rq.pop_front());
		chk_o(exp_out_o, mo);
		@(posedge mclk_i); #2;
	endtask
	initial forever #25 mclk_i = ~mclk_i;
	initial begin #300us; n_fail++; conclude; end
	initial begin
		repeat (4) @(posedge mclk_i); #2 resetn_i = 1;
		acc(1, 1, 1, 4'h2, 7'h07, 5'h03, 32'h6);
		acc(0, 1, 1, 4'h2, 7'h08, 5'h02, 32'h0);
		acc(1, 1, 0, 4'h2, 7'h07, 5'h00, 32'hFFFFFFFD);
		acc(0, 1, 0, 4'h2, 7'h07, 5'h00, 32'h0);
		acc(1, 1, 1, 4'h4, 7'h2E, 5'h03, 32'h7);
		acc(0, 1, 1, 4'h4, 7'h28, 5'h18, 32'h0);
		acc(0, 0, 1, 4'h1, 7'h00, 5'h00, 32'h0);
		$display("directed done");
		for (i = 0; i < 400; i++) begin
			if (i % 40 == 0) begin pat = {6{$random(seed)}}; repeat (3) @(posedge mclk_i); #2; end
			if (i == 200) begin
				resetn_i = 0; @(posedge mclk_i); #2;
				chk_v(rvalid_o, 0); chk_d(rdata_o, 0);
				chk_o(exp_out_o, 0); mo = 0; lr = 0;
				resetn_i = 1; repeat (2) @(posedge mclk_i); #2;
			end
			acc($random(seed), $random(seed), $random(seed), {$random(seed)} % 6,
				{$random(seed)} % 50, {$random(seed)} % 26, $random(seed));
		end
		$display("random done");
		conclude;
	end
endmodule // eio_point_access_bench
